// ### rtl/decode_pkg.sv
package decode_pkg;
    // Instruction word layout.
    localparam int WORD_W = 24;
    localparam int OPC_W = 8;
    localparam int OPC_LSB = 16;
    // Register operand fields: 4-bit register number plus 3-bit address mode.
    localparam int BASE_LSB = 11;
    localparam int DST_MODE_LSB = 11;
    localparam int DST_REG_LSB = 7;
    localparam int SRC_MODE_LSB = 4;
    localparam int SRC_REG_LSB = 0;
    localparam int BYTE_BIT = 14;
    localparam int DIR_BIT = 13;
    localparam int FILE_LSB = 0;
    localparam int FILE_W = 13;
    localparam int BITPOS_LSB = 12;
    localparam int LIT_LSB = 4;
    localparam int LIT_W = 16;
    localparam int ADDR_W = 23;
    localparam int TBL_MODE_LSB = 19;
    // Two-word opcodes, table opcodes and the second-word marker.
    localparam logic [7:0] OPC_NOP = 8'h00;
    localparam logic [7:0] OPC_CALL = 8'h02;
    localparam logic [7:0] OPC_GOTO = 8'h04;
    localparam logic [7:0] OPC_DO = 8'h08;
    localparam logic [7:0] OPC_TBL_LO = 8'hB8;
    localparam logic [7:0] OPC_TBL_HI = 8'hBB;
    // Category boundaries on the top opcode nibble.
    localparam logic [3:0] NIB_CTRL_HI = 4'h3;
    localparam logic [3:0] NIB_LIT_HI = 4'h2;
    localparam logic [3:0] NIB_BIT = 4'hA;
    localparam logic [3:0] NIB_MOVLIT = 4'h2;
    localparam logic [3:0] NIB_ARITH_LO = 4'h4;
    localparam logic [3:0] NIB_ARITH_HI = 4'h7;
    localparam logic [3:0] NIB_FILE = 4'hB;
    localparam logic [3:0] NIB_FILE2 = 4'hE;
    localparam int NORMAL_CYCLES = 1;
    localparam int LONG_CYCLES = 2;
    localparam logic [3:0] DEFAULT_WORK_REG_NUM = 4'h0;

    typedef enum logic [1:0] {
        CAT_WORD_BYTE = 2'b00,
        CAT_BIT = 2'b01,
        CAT_LITERAL = 2'b10,
        CAT_CONTROL = 2'b11
    } category_t;

    typedef enum logic [1:0] {
        ST_FIRST = 2'b00,
        ST_SECOND = 2'b01,
        ST_FLUSH = 2'b10
    } dec_state_t;
endpackage

// ### rtl/field_if.sv
`timescale 1ns/1ps
// Raw operand fields cut from one word, shared by the splitter and the decoder.
interface field_if;
    logic [7:0] opcode;
    logic [3:0] base_source_reg;
    logic [3:0] second_source_reg;
    logic [2:0] second_source_mode;
    logic [3:0] destination_reg;
    logic [2:0] destination_mode;
    logic [12:0] file_addr;
    logic [15:0] literal;
    logic [3:0] bit_pos;
    logic [22:0] addr_part;
    logic [1:0] tbl_mode;
    logic byte_op;
    logic dest_is_file;
    modport split (output opcode, base_source_reg, second_source_reg, second_source_mode,
        destination_reg, destination_mode, file_addr, literal, bit_pos, addr_part, tbl_mode,
        byte_op, dest_is_file);
    modport use_fields (input opcode, base_source_reg, second_source_reg, second_source_mode,
        destination_reg, destination_mode, file_addr, literal, bit_pos, addr_part, tbl_mode,
        byte_op, dest_is_file);
endinterface

// ### rtl/field_splitter.sv
`timescale 1ns/1ps
// Pure wiring of bit fields; the decoder decides which of them mean anything.
module field_splitter (
    // Incoming word.
    input wire logic [decode_pkg::WORD_W-1:0] word,
    // Cut fields.
    field_if.split f
);
    import decode_pkg::*;

    // Every field is cut at a fixed place so the cost is only wires.
    assign f.opcode = word[OPC_LSB +: OPC_W];
    assign f.base_source_reg = word[BASE_LSB +: 4];
    assign f.destination_mode = word[DST_MODE_LSB +: 3];
    assign f.destination_reg = word[DST_REG_LSB +: 4];
    assign f.second_source_mode = word[SRC_MODE_LSB +: 3];
    assign f.second_source_reg = word[SRC_REG_LSB +: 4];
    assign f.file_addr = word[FILE_LSB +: FILE_W];
    assign f.literal = word[LIT_LSB +: LIT_W];
    assign f.bit_pos = word[BITPOS_LSB +: 4];
    assign f.addr_part = word[ADDR_W-1:0];
    assign f.tbl_mode = word[TBL_MODE_LSB +: 2];
    assign f.byte_op = word[BYTE_BIT];
    assign f.dest_is_file = word[DIR_BIT];
endmodule // field_splitter

// ### rtl/instruction_operand_decoder.sv
`timescale 1ns/1ps
// Behaviour
// - Word is 24 bits; the top 8 bits are the opcode, the rest operands.
// - Three two-word instructions collect their second word before being reported decoded.
// - Every instruction falls in exactly one of four categories.
// - Register ops give base source, second source with mode, destination with mode.
// - File ops give file address and a selector for file or default register.
// - Bit ops give register or file operand and literal or register bit position.
// - Literal moves give the literal and its target register or file address.
// - Literal arithmetic gives base source, literal, destination only if different.
// - Control ops give a program address or a table access mode.
// - A lone second word, upper byte zero, decodes as a no-operation.
// - One cycle normally; two, second a no-operation, on true test or jump.
module instruction_operand_decoder (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rstn,
    // From the fetch stage.
    input wire logic fetch_valid,
    input wire logic [decode_pkg::WORD_W-1:0] fetch_word,
    // From the execution stage: the current instruction took a branch or a true test.
    input wire logic exec_redirect,
    // To the execution stage; fetch_ready goes back to the fetch stage.
    output logic dec_valid,
    output logic fetch_ready,
    output decode_pkg::category_t category,
    output logic [7:0] opcode,
    output logic is_nop,
    output logic two_word,
    output logic byte_op,
    output logic [3:0] base_source_reg,
    output logic [3:0] second_source_reg,
    output logic [2:0] second_source_mode,
    output logic [3:0] destination_reg,
    output logic [2:0] destination_mode,
    output logic dest_valid,
    output logic dest_is_file,
    output logic [12:0] file_addr,
    output logic [15:0] literal,
    output logic [3:0] bit_pos,
    output logic bit_pos_indirect,
    output logic [22:0] prog_addr,
    output logic [1:0] tbl_mode
);
    import decode_pkg::*;

    field_if fi();
    dec_state_t state;
    logic [WORD_W-1:0] first_word;
    logic [3:0] nib;
    logic needs_second;
    logic [7:0] hold_opc;
    category_t next_category;

    field_splitter u_split (
        .word(fetch_word),
        .f(fi)
    );

    assign nib = fi.opcode[7:4];
    // Only three opcodes span two words; anything else is complete at once.
    assign needs_second = (fi.opcode == OPC_CALL) || (fi.opcode == OPC_GOTO)
        || (fi.opcode == OPC_DO);
    // Fetch is accepted except during the forced no-operation slot and the redirect cycle before it.
    assign fetch_ready = (state != ST_FLUSH);
    assign hold_opc = first_word[OPC_LSB +: OPC_W];

    // Category from the opcode; each value maps to one class only.
    always_comb begin
        if (nib <= NIB_CTRL_HI && nib != NIB_MOVLIT) begin
            next_category = CAT_CONTROL;
        end else if (nib == NIB_BIT) begin
            next_category = CAT_BIT;
        end else if (nib == NIB_MOVLIT || (nib == NIB_FILE && fi.opcode[3])) begin
            next_category = CAT_LITERAL;
        end else begin
            next_category = CAT_WORD_BYTE;
        end
    end

    // Sequencer for two-word fetches and the extra no-operation cycle.
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            state <= ST_FIRST;
        end else begin
            case (state)
                ST_FIRST: begin
                    if (exec_redirect && dec_valid) begin
                        state <= ST_FLUSH;
                    end else if (fetch_valid && needs_second) begin
                        state <= ST_SECOND;
                    end
                end
                ST_SECOND: begin
                    if (fetch_valid) begin
                        state <= ST_FIRST;
                    end
                end
                ST_FLUSH: state <= ST_FIRST;
                default: state <= ST_FIRST;
            endcase
        end
    end

    // The first word is kept while the second one is awaited.
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            first_word <= '0;
        end else if (state == ST_FIRST && fetch_valid && needs_second) begin
            first_word <= fetch_word;
        end
    end

    // Valid rises only when a whole instruction is present; a flush slot is a bubble.
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            dec_valid <= 1'b0;
        end else begin
            dec_valid <= fetch_valid && fetch_ready && (state == ST_SECOND || !needs_second)
                && !(state == ST_FIRST && exec_redirect && dec_valid);
        end
    end

    // Operand registers load once per instruction and otherwise hold, except is_nop and opcode, which also load on a redirect.
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            category <= CAT_CONTROL;
            opcode <= OPC_NOP;
            is_nop <= 1'b1;
            two_word <= 1'b0;
            byte_op <= 1'b0;
            base_source_reg <= '0;
            second_source_reg <= '0;
            second_source_mode <= '0;
            destination_reg <= '0;
            destination_mode <= '0;
            dest_valid <= 1'b0;
            dest_is_file <= 1'b0;
            file_addr <= '0;
            literal <= '0;
            bit_pos <= '0;
            bit_pos_indirect <= 1'b0;
            prog_addr <= '0;
            tbl_mode <= '0;
        end else if (state == ST_SECOND && fetch_valid) begin
            // Second word joins the held first word into one control operation.
            category <= CAT_CONTROL;
            opcode <= hold_opc;
            is_nop <= 1'b0;
            two_word <= 1'b1;
            prog_addr <= {fetch_word[6:0], first_word[15:0]};
        end else if (state == ST_FIRST && fetch_valid && !needs_second
            && !(exec_redirect && dec_valid)) begin
            category <= next_category;
            opcode <= fi.opcode;
            // A stray second word has a zero upper byte and is harmless.
            is_nop <= (fi.opcode == OPC_NOP);
            two_word <= 1'b0;
            byte_op <= fi.byte_op;
            base_source_reg <= fi.base_source_reg;
            second_source_reg <= fi.second_source_reg;
            second_source_mode <= fi.second_source_mode;
            destination_reg <= fi.destination_reg;
            destination_mode <= fi.destination_mode;
            file_addr <= fi.file_addr;
            dest_is_file <= fi.dest_is_file;
            literal <= fi.literal;
            tbl_mode <= fi.tbl_mode;
            prog_addr <= {7'h00, fi.addr_part[15:0]};
            bit_pos <= fi.bit_pos;
            bit_pos_indirect <= (next_category == CAT_BIT) && fi.opcode[3];
            // Arithmetic literal ops name a destination only when it differs from the base.
            if (nib >= NIB_ARITH_LO && nib <= NIB_ARITH_HI && fi.opcode[3]) begin
                dest_valid <= (fi.destination_reg != fi.base_source_reg);
            end else begin
                dest_valid <= (next_category == CAT_WORD_BYTE) || (nib == NIB_FILE2);
            end
            // Literal move targets the second source register; a nibble E file op with no file target loads the default working register.
            if (next_category == CAT_LITERAL && nib == NIB_MOVLIT) begin
                destination_reg <= fi.second_source_reg;
            end else if (next_category == CAT_WORD_BYTE && nib == NIB_FILE2
                && !fi.dest_is_file) begin
                destination_reg <= DEFAULT_WORK_REG_NUM;
            end
        end else if (state == ST_FIRST && exec_redirect && dec_valid) begin
            // Loaded on the redirect edge so the no-operation stands during the flush slot itself.
            is_nop <= 1'b1;
            opcode <= OPC_NOP;
        end
    end
endmodule // instruction_operand_decoder

// ### test/iod_props.sv
`timescale 1ns/1ps
// Port-level checks of the decoder; helper logic tracks two-word pairing.
module iod_props (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rstn,
    // Fetch side.
    input wire logic fetch_valid,
    input wire logic fetch_ready,
    input wire logic [23:0] fetch_word,
    input wire logic exec_redirect,
    // Decoder outputs.
    input wire logic dec_valid,
    input wire decode_pkg::category_t category,
    input wire logic [7:0] opcode,
    input wire logic is_nop,
    input wire logic two_word,
    input wire logic [3:0] bit_pos,
    input wire logic bit_pos_indirect,
    input wire logic [15:0] literal,
    input wire logic [22:0] prog_addr
);
    import decode_pkg::*;
    logic take;
    logic first;
    logic pend;
    logic [15:0] lo;
    category_t cat;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    // A word offered while a redirect is seen is dropped, so it is not taken.
    assign take = fetch_valid && fetch_ready && !(dec_valid && exec_redirect);
    assign first = !pend && fetch_word[23:16] inside {OPC_CALL, OPC_GOTO, OPC_DO};
    // Expected class from the top opcode nibble.
    always_comb begin
        case (fetch_word[23:20])
            4'h0, 4'h1, 4'h3: cat = CAT_CONTROL;
            4'h2: cat = CAT_LITERAL;
            4'hA: cat = CAT_BIT;
            4'hB: cat = fetch_word[19] ? CAT_LITERAL : CAT_WORD_BYTE;
            default: cat = CAT_WORD_BYTE;
        endcase
    end
    // Remembers a first word until its partner arrives.
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            pend <= 1'b0;
        end else if (take) begin
            pend <= first;
        end
    end
    // Low 16 bits of the program address from the first word.
    always_ff @(posedge ref_clk) begin
        if (take && first) begin
            lo <= fetch_word[15:0];
        end
    end
    AST_SINGLE: assert property (take && !pend && !first |=> dec_valid && opcode == $past(fetch_word[23:16]))
        else $error("single word not decoded");
    AST_CAT: assert property (take && !pend && !first |=> category == $past(cat))
        else $error("wrong category");
    AST_PAIR_WAIT: assert property (take && first |=> !dec_valid)
        else $error("first word reported alone");
    AST_PAIR_DONE: assert property (take && pend |=> dec_valid && two_word && prog_addr == {$past(fetch_word[6:0]), lo})
        else $error("pair not joined");
    AST_LONE_NOP: assert property (take && !pend && fetch_word[23:16] == OPC_NOP |=> is_nop)
        else $error("lone word not a no-op");
    AST_BIT: assert property (take && !pend && fetch_word[23:20] == NIB_BIT |=> bit_pos == $past(fetch_word[15:12]) && bit_pos_indirect == $past(fetch_word[19]))
        else $error("bit operand wrong");
    AST_MOVLIT: assert property (take && !pend && fetch_word[23:20] == NIB_MOVLIT |=> literal == $past(fetch_word[19:4]))
        else $error("literal wrong");
    AST_FLUSH: assert property (dec_valid && exec_redirect |=> !fetch_ready && is_nop && !dec_valid ##1 fetch_ready)
        else $error("no single flush cycle");
    AST_HOLD: assert property (!dec_valid && !pend && fetch_ready |-> $stable(opcode) && $stable(category))
        else $error("fields moved without decode");
endmodule // iod_props
bind instruction_operand_decoder iod_props i_props (.*);

// ### test/fetch_model.sv
`timescale 1ns/1ps
// Fetch stage and branch unit stand-in; a refused word is held until taken.
module fetch_model (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rstn,
    // Decoder handshake.
    input wire logic fetch_ready,
    input wire logic dec_valid,
    output logic fetch_valid,
    output logic [23:0] fetch_word,
    output logic exec_redirect
);
    logic [23:0] words[$];
    bit redir[$];
    bit slow = 0;
    bit took = 0;
    initial fetch_valid = 0;
    initial fetch_word = 24'h00_0000;
    initial exec_redirect = 0;
    // The offer counts as taken only if no redirect dropped it.
    always @(posedge ref_clk) took = fetch_valid && fetch_ready && rstn && !(dec_valid && exec_redirect);
    // Idle word toggles so a stale value never looks valid.
    always @(negedge ref_clk) begin
        if (took) void'(words.pop_front());
        exec_redirect <= dec_valid && redir.size() > 0 && redir.pop_front();
        if (words.size() > 0 && !(took && slow)) begin
            fetch_valid <= 1;
            fetch_word <= words[0];
        end else begin
            fetch_valid <= 0;
            fetch_word <= ~fetch_word;
        end
    end
endmodule // fetch_model

// ### test/instruction_operand_decoder_tb.sv
`timescale 1ns/1ps
// Queues instructions to the fetch model and checks each decoded result.
module instruction_operand_decoder_tb;
    import decode_pkg::*;
    typedef struct {logic [7:0] op; logic two; logic nop; logic [22:0] pa;} exp_t;
    logic ref_clk = 0;
    logic rstn = 0;
    logic fetch_valid, fetch_ready, exec_redirect, dec_valid, is_nop, two_word;
    logic [23:0] fetch_word, w;
    logic [7:0] opcode;
    logic [22:0] prog_addr;
    logic [7:0] pair_op[3] = '{OPC_CALL, OPC_GOTO, OPC_DO};
    int seed = 32'ha051;
    int err_total = 0;
    int n_checks = 0;
    exp_t exp_q[$];
    exp_t e;
    always #5 ref_clk = ~ref_clk;
    fetch_model i_fetch (.ref_clk(ref_clk), .rstn(rstn), .fetch_ready(fetch_ready),
        .dec_valid(dec_valid), .fetch_valid(fetch_valid), .fetch_word(fetch_word),
        .exec_redirect(exec_redirect));
    instruction_operand_decoder i_dut (.ref_clk(ref_clk), .rstn(rstn),
        .fetch_valid(fetch_valid), .fetch_word(fetch_word), .exec_redirect(exec_redirect),
        .dec_valid(dec_valid), .fetch_ready(fetch_ready), .category(), .opcode(opcode),
        .is_nop(is_nop), .two_word(two_word), .byte_op(), .base_source_reg(),
        .second_source_reg(), .second_source_mode(), .destination_reg(),
        .destination_mode(), .dest_valid(), .dest_is_file(), .file_addr(), .literal(),
        .bit_pos(), .bit_pos_indirect(), .prog_addr(prog_addr), .tbl_mode());
    task automatic check(string what, logic [31:0] seen, logic [31:0] want);
        n_checks++;
        if (seen !== want) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, want, seen);
        end
    endtask
    task automatic stop_test();
        if (err_total == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Random single word in one opcode nibble; pair openers are avoided.
    function automatic logic [23:0] rnd(logic [3:0] nib);
        logic [23:0] r;
        r = $random(seed);
        r[23:20] = nib;
        if (r[23:16] inside {OPC_CALL, OPC_GOTO, OPC_DO}) r[23:16] = 8'h01;
        return r;
    endfunction
    task automatic send(logic [23:0] w1, logic [23:0] w2, bit two, bit br);
        i_fetch.words.push_back(w1);
        if (two) i_fetch.words.push_back(w2);
        i_fetch.redir.push_back(br);
        exp_q.push_back('{w1[23:16], two, w1[23:16] == OPC_NOP, {w2[6:0], w1[15:0]}});
    endtask
    // Bounded wait until every note has been matched.
    task automatic drain();
        for (int i = 0; i < 3000 && exp_q.size() > 0; i++) @(negedge ref_clk);
        check("pending notes", exp_q.size(), 0);
    endtask
    // Each decoded instruction is matched against the oldest note.
    always @(negedge ref_clk) begin
        if (rstn && dec_valid === 1'b1) begin
            e = exp_q.pop_front();
            check("opcode", opcode, e.op);
            check("two_word", two_word, e.two);
            check("is_nop", is_nop, e.nop);
            if (e.two) check("prog_addr", prog_addr, e.pa);
        end
    end
    // Watchdog well beyond the expected run length.
    initial begin
        #200000;
        err_total++;
        stop_test();
    end
    initial begin
        repeat (6) @(negedge ref_clk);
        rstn = 1;
        for (int p = 0; p < 2; p++) begin
            @(posedge ref_clk);
            i_fetch.slow = p;
            send(24'h00_1234, 24'h00_0000, 0, 0);
            for (int k = 0; k < 48; k++) begin
                w = rnd(k[3:0]);
                send(w, 24'h00_0000, 0, k % 5 == 2);
            end
            foreach (pair_op[i]) begin
                w = rnd(4'h1);
                send({pair_op[i], w[15:0]}, {8'h00, w[23:8]}, 1, i == p);
            end
            send(rnd(4'hA), 24'h00_0000, 0, 0);
            drain();
        end
        rstn = 0;
        repeat (2) @(negedge ref_clk);
        check("reset is_nop", is_nop, 1);
        check("reset dec_valid", dec_valid, 0);
        rstn = 1;
        @(posedge ref_clk);
        send(rnd(4'h2), 24'h00_0000, 0, 0);
        drain();
        stop_test();
    end
endmodule // instruction_operand_decoder_tb
